/* File: hw/adc_mon_pkg.sv */
// shared constants and types of the converter control and status port logic
package adc_mon_pkg;

  // ------------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned CONV_TIME_NS = 104;
  localparam int unsigned CAL_TIME_NS = 4000;
  // least times, rounded up to whole cycles
  localparam int unsigned CONV_CYCLES = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CAL_CYCLES = (CAL_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned TIMER_W = 11;
  localparam logic [TIMER_W-1:0] CONV_LOAD = TIMER_W'(CONV_CYCLES);
  localparam logic [TIMER_W-1:0] CAL_LOAD = TIMER_W'(CAL_CYCLES);

  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CHAN_W = 5;
  localparam int unsigned NUM_CHAN = 32;
  localparam int unsigned SAMPLE_W = 12;
  localparam int unsigned ALARM_W = 8;
  localparam int unsigned SENSOR_ALARMS = 7;
  localparam int unsigned CFG_WORDS = 96;

  // ------------------------------------------------------------------
  // field positions and address split
  // ------------------------------------------------------------------
  localparam int unsigned ALM_TEMP = 0;
  localparam int unsigned ALM_CORE = 1;
  localparam int unsigned ALM_AUX = 2;
  localparam int unsigned ALM_BRAM = 3;
  localparam int unsigned ALM_PS_FIRST = 4;
  localparam int unsigned ALM_PS_LAST = 6;
  localparam int unsigned ALM_ANY = 7;
  localparam logic [ADDR_W-1:0] CFG_BASE = 7'h20;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [CHAN_W-1:0] CHAN_RESET = 5'h00;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [ALARM_W-1:0] ALARM_RESET = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONVERT = 3'b010,
    ST_CALIBRATE = 3'b100
  } conv_state_e;

endpackage

/* File: hw/rise_detect.sv */
// rising edge detector for a synchronous level input
`timescale 1ns/1ps
`default_nettype none

module rise_detect (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // level in, pulse out
  input wire logic level,
  output logic rise
);

  logic level_q;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      level_q <= 1'b0;
    end else if (clk_en) begin
      level_q <= level;
    end
  end

  // combinational so the start is not delayed a further cycle
  assign rise = level & ~level_q;

endmodule

`default_nettype wire

/* File: hw/cycle_timer.sv */
// down counter that times one conversion or calibration
`timescale 1ns/1ps
`default_nettype none

module cycle_timer #(
  parameter int unsigned W = 11
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // control
  input wire logic start,
  input wire logic [W-1:0] load,
  // status
  output logic running,
  output logic done
);

  logic [W-1:0] count;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count <= '0;
    end else if (clk_en) begin
      if (start) begin
        count <= load;
      end else if (count != '0) begin
        count <= count - W'(1);
      end
    end
  end

  assign running = (count != '0);
  // last counted cycle
  assign done = (count == W'(1));

endmodule

`default_nettype wire

/* File: hw/adc_monitor_status_ports.sv */
// converter control, channel sequencing, status flags and register ports
`timescale 1ns/1ps
`default_nettype none

module adc_monitor_status_ports (
  // clock, enable and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // operating mode
  input wire logic event_mode,
  input wire logic use_trigger_clock,
  input wire logic external_mux_mode,
  input wire logic calibrate_request,
  input wire logic [adc_mon_pkg::NUM_CHAN-1:0] sequence_mask,
  // conversion triggers
  input wire logic conversion_trigger,
  input wire logic trigger_clock_input,
  // converter and comparator results
  input wire logic [adc_mon_pkg::SAMPLE_W-1:0] sample_data,
  input wire logic [adc_mon_pkg::SENSOR_ALARMS-1:0] sensor_alarm_in,
  input wire logic overheat_in,
  // status outputs
  output logic [adc_mon_pkg::ALARM_W-1:0] alarm,
  output logic overheat_alarm,
  output logic [adc_mon_pkg::CHAN_W-1:0] external_mux_select,
  output logic [adc_mon_pkg::CHAN_W-1:0] channel,
  output logic conversion_done,
  output logic sequence_done,
  output logic busy,
  // fabric side of the configuration register port
  input wire logic port_enable,
  input wire logic port_write_enable,
  input wire logic [adc_mon_pkg::ADDR_W-1:0] port_address,
  input wire logic [adc_mon_pkg::DATA_W-1:0] port_write_data,
  output logic [adc_mon_pkg::DATA_W-1:0] port_read_data,
  output logic port_ack,
  // scan side of the configuration register port
  input wire logic scan_lock_request,
  input wire logic scan_enable,
  input wire logic scan_write_enable,
  input wire logic [adc_mon_pkg::ADDR_W-1:0] scan_address,
  input wire logic [adc_mon_pkg::DATA_W-1:0] scan_write_data,
  output logic [adc_mon_pkg::DATA_W-1:0] scan_read_data,
  output logic scan_ack,
  output logic port_lock_flag,
  output logic scan_write_flag,
  output logic scan_access_busy
);

  // ------------------------------------------------------------------
  // channel sequence helpers
  // ------------------------------------------------------------------
  function automatic logic [adc_mon_pkg::CHAN_W-1:0] next_in_seq(
    input logic [adc_mon_pkg::NUM_CHAN-1:0] mask,
    input logic [adc_mon_pkg::CHAN_W-1:0] cur
  );
    logic [adc_mon_pkg::CHAN_W-1:0] cand;
    logic found;
    next_in_seq = cur;
    found = 1'b0;
    for (int i = 1; i <= adc_mon_pkg::NUM_CHAN; i++) begin
      cand = cur + adc_mon_pkg::CHAN_W'(i);
      if (!found && mask[cand]) begin
        next_in_seq = cand;
        found = 1'b1;
      end
    end
  endfunction

  function automatic logic last_in_seq(
    input logic [adc_mon_pkg::NUM_CHAN-1:0] mask,
    input logic [adc_mon_pkg::CHAN_W-1:0] cur
  );
    last_in_seq = (mask != '0);
    for (int i = 0; i < adc_mon_pkg::NUM_CHAN; i++) begin
      if (i > int'(cur) && mask[i]) begin
        last_in_seq = 1'b0;
      end
    end
  endfunction

  // ------------------------------------------------------------------
  // trigger detection and timers
  // ------------------------------------------------------------------
  adc_mon_pkg::conv_state_e state;
  adc_mon_pkg::conv_state_e next_state;
  logic [adc_mon_pkg::CHAN_W-1:0] cur_chan;
  logic [adc_mon_pkg::CHAN_W-1:0] next_chan;
  logic [adc_mon_pkg::CHAN_W-1:0] upcoming;
  logic trig_rise;
  logic clkin_rise;
  logic event_start;
  logic conv_start;
  logic cal_start;
  logic conv_end;
  logic cal_end;

  rise_detect u_trig_edge (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .level(conversion_trigger),
    .rise(trig_rise)
  );

  rise_detect u_clkin_edge (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .level(trigger_clock_input),
    .rise(clkin_rise)
  );

  // the two trigger sources are alternatives; only one is honoured at a time
  assign event_start = use_trigger_clock ? clkin_rise : trig_rise;

  cycle_timer #(.W(adc_mon_pkg::TIMER_W)) u_conv_timer (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .start(conv_start),
    .load(adc_mon_pkg::CONV_LOAD),
    .running(),
    .done(conv_end)
  );

  cycle_timer #(.W(adc_mon_pkg::TIMER_W)) u_cal_timer (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .start(cal_start),
    .load(adc_mon_pkg::CAL_LOAD),
    .running(),
    .done(cal_end)
  );

  // ------------------------------------------------------------------
  // conversion state machine
  // ------------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      adc_mon_pkg::ST_IDLE: begin
        // calibration takes precedence over a pending trigger
        if (calibrate_request) begin
          next_state = adc_mon_pkg::ST_CALIBRATE;
        end else if (!event_mode || event_start) begin
          next_state = adc_mon_pkg::ST_CONVERT;
        end
      end
      adc_mon_pkg::ST_CONVERT: begin
        if (conv_end) begin
          next_state = adc_mon_pkg::ST_IDLE;
        end
      end
      adc_mon_pkg::ST_CALIBRATE: begin
        if (cal_end) begin
          next_state = adc_mon_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = adc_mon_pkg::ST_IDLE;
      end
    endcase
  end

  assign conv_start = (state == adc_mon_pkg::ST_IDLE) && (next_state == adc_mon_pkg::ST_CONVERT);
  assign cal_start = (state == adc_mon_pkg::ST_IDLE) && (next_state == adc_mon_pkg::ST_CALIBRATE);
  assign upcoming = (state == adc_mon_pkg::ST_CONVERT) ? next_in_seq(sequence_mask, cur_chan)
                                                      : next_chan;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= adc_mon_pkg::ST_IDLE;
      busy <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      busy <= (next_state != adc_mon_pkg::ST_IDLE);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cur_chan <= adc_mon_pkg::CHAN_RESET;
      next_chan <= adc_mon_pkg::CHAN_RESET;
      external_mux_select <= adc_mon_pkg::CHAN_RESET;
    end else if (clk_en) begin
      if (conv_start) begin
        cur_chan <= next_chan;
      end
      if (conv_end && state == adc_mon_pkg::ST_CONVERT) begin
        next_chan <= next_in_seq(sequence_mask, cur_chan);
      end
      external_mux_select <= external_mux_mode ? upcoming : adc_mon_pkg::CHAN_RESET;
    end
  end

  // ------------------------------------------------------------------
  // result write and end-of-conversion flags
  // ------------------------------------------------------------------
  logic [adc_mon_pkg::DATA_W-1:0] status_mem [adc_mon_pkg::NUM_CHAN];
  logic result_write;

  assign result_write = conv_end && (state == adc_mon_pkg::ST_CONVERT);

  always_ff @(posedge core_clk) begin
    if (clk_en && result_write) begin
      // left aligned, as the 12-bit code sits in the upper bits of a word
      status_mem[cur_chan] <= {sample_data, 4'h0};
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      channel <= adc_mon_pkg::CHAN_RESET;
      conversion_done <= 1'b0;
      sequence_done <= 1'b0;
    end else if (clk_en) begin
      conversion_done <= result_write;
      sequence_done <= result_write && last_in_seq(sequence_mask, cur_chan);
      if (result_write) begin
        channel <= cur_chan;
      end
    end
  end

  // ------------------------------------------------------------------
  // alarm outputs
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      alarm <= adc_mon_pkg::ALARM_RESET;
      overheat_alarm <= 1'b0;
    end else if (clk_en) begin
      alarm[adc_mon_pkg::ALM_PS_LAST:adc_mon_pkg::ALM_TEMP] <= sensor_alarm_in;
      alarm[adc_mon_pkg::ALM_ANY] <= |sensor_alarm_in;
      overheat_alarm <= overheat_in;
    end
  end

  // ------------------------------------------------------------------
  // configuration register port, fabric and scan sides
  // ------------------------------------------------------------------
  logic [adc_mon_pkg::DATA_W-1:0] cfg_mem [adc_mon_pkg::CFG_WORDS];
  logic scan_write;
  logic port_write;

  assign scan_write = scan_enable && scan_write_enable && (scan_address >= adc_mon_pkg::CFG_BASE);
  // fabric writes are dropped while the scan side holds the lock
  assign port_write = port_enable && port_write_enable && !port_lock_flag
                      && (port_address >= adc_mon_pkg::CFG_BASE);

  always_ff @(posedge core_clk) begin
    if (clk_en) begin
      if (scan_write) begin
        cfg_mem[scan_address - adc_mon_pkg::CFG_BASE] <= scan_write_data;
      end else if (port_write) begin
        cfg_mem[port_address - adc_mon_pkg::CFG_BASE] <= port_write_data;
      end
    end
  end

  function automatic logic [adc_mon_pkg::DATA_W-1:0] read_word(
    input logic [adc_mon_pkg::ADDR_W-1:0] addr
  );
    if (addr < adc_mon_pkg::CFG_BASE) begin
      read_word = status_mem[addr[adc_mon_pkg::CHAN_W-1:0]];
    end else begin
      read_word = cfg_mem[addr - adc_mon_pkg::CFG_BASE];
    end
  endfunction

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      port_ack <= 1'b0;
      port_read_data <= adc_mon_pkg::DATA_RESET;
    end else if (clk_en) begin
      port_ack <= port_enable;
      if (port_enable && !port_write_enable) begin
        port_read_data <= read_word(port_address);
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      port_lock_flag <= 1'b0;
      scan_access_busy <= 1'b0;
      scan_ack <= 1'b0;
      scan_read_data <= adc_mon_pkg::DATA_RESET;
    end else if (clk_en) begin
      port_lock_flag <= scan_lock_request;
      scan_access_busy <= scan_enable;
      scan_ack <= scan_access_busy;
      if (scan_enable && !scan_write_enable) begin
        scan_read_data <= read_word(scan_address);
      end
    end
  end

  // a fabric write acknowledges the change; a new scan write in that cycle wins
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      scan_write_flag <= 1'b0;
    end else if (clk_en) begin
      if (scan_enable && scan_write_enable) begin
        scan_write_flag <= 1'b1;
      end else if (port_write) begin
        scan_write_flag <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  sequence conv_entered;
    (state == adc_mon_pkg::ST_CONVERT) && $past(state) != adc_mon_pkg::ST_CONVERT;
  endsequence
  sequence cal_entered;
    (state == adc_mon_pkg::ST_CALIBRATE) && $past(state) != adc_mon_pkg::ST_CALIBRATE;
  endsequence

  a_alarm_any_or: assert property (@(posedge core_clk iff clk_en) disable iff (reset)
    alarm[adc_mon_pkg::ALM_ANY] == |alarm[adc_mon_pkg::ALM_PS_LAST:adc_mon_pkg::ALM_TEMP])
    else $error("combined alarm differs from OR of sensor alarms");
  a_event_gate: assert property (@(posedge core_clk iff clk_en) disable iff (reset)
    (state == adc_mon_pkg::ST_IDLE && event_mode && !event_start && !calibrate_request)
    |=> state == adc_mon_pkg::ST_IDLE)
    else $error("conversion started without a trigger in event mode");
  a_conv_busy_len: assert property (@(posedge core_clk iff clk_en) disable iff (reset)
    conv_entered |-> busy [*8] ##19 conversion_done)
    else $error("conversion length or busy wrong");
  a_cal_busy_hold: assert property (@(posedge core_clk iff clk_en) disable iff (reset)
    cal_entered |-> busy [*8])
    else $error("busy dropped during calibration");
  a_done_pulse_once: assert property (@(posedge core_clk iff clk_en) disable iff (reset)
    conversion_done |=> !conversion_done && !sequence_done)
    else $error("done flag longer than one cycle");
  a_seq_needs_eoc: assert property (@(posedge core_clk iff clk_en) disable iff (reset)
    sequence_done |-> conversion_done && last_in_seq(sequence_mask, channel))
    else $error("sequence done without last conversion");
  a_chan_on_done: assert property (@(posedge core_clk iff clk_en) disable iff (reset)
    conversion_done |-> channel == cur_chan && $past(state) == adc_mon_pkg::ST_CONVERT)
    else $error("channel indication wrong at end of conversion");
  a_mux_off_zero: assert property (@(posedge core_clk iff clk_en) disable iff (reset)
    !external_mux_mode |=> external_mux_select == adc_mon_pkg::CHAN_RESET)
    else $error("mux select driven outside external mode");
  a_lock_follows: assert property (@(posedge core_clk iff clk_en) disable iff (reset)
    port_lock_flag == $past(scan_lock_request))
    else $error("lock flag does not follow lock request");
  a_scan_busy_ack: assert property (@(posedge core_clk iff clk_en) disable iff (reset)
    scan_enable |=> scan_access_busy ##1 scan_ack)
    else $error("scan transaction busy or ack missing");
  a_scan_write_set: assert property (@(posedge core_clk iff clk_en) disable iff (reset)
    scan_enable && scan_write_enable |=> scan_write_flag)
    else $error("scan write not flagged");
  a_port_ack_next: assert property (@(posedge core_clk iff clk_en) disable iff (reset)
    port_enable |=> port_ack ##1 !port_ack || $past(port_enable))
    else $error("port ack missing");

endmodule

`default_nettype wire

/* File: dv/scan_tap_model.sv */
// model of the scan side: lock request and single-cycle scan writes
`timescale 1ns/1ps
`default_nettype none

module scan_tap_model (
  // clock
  input wire logic core_clk,
  // answers from the port
  input wire logic scan_ack,
  input wire logic scan_access_busy,
  input wire logic [15:0] scan_read_data,
  // requests
  output logic scan_lock_request,
  output logic scan_enable,
  output logic scan_write_enable,
  output logic [6:0] scan_address,
  output logic [15:0] scan_write_data
);
  logic busy_seen;

  initial begin
    scan_lock_request = 1'b0;
    scan_enable = 1'b0;
    scan_write_enable = 1'b0;
    scan_address = 7'h00;
    scan_write_data = 16'h0000;
    busy_seen = 1'b0;
  end

  task automatic lock(input logic on);
    @(posedge core_clk);
    scan_lock_request <= on;
  endtask

  // fields are inverted after the strobe so nothing can lean on stale values
  task automatic write(input logic [6:0] addr, input logic [15:0] data);
    @(posedge core_clk);
    scan_enable <= 1'b1;
    scan_write_enable <= 1'b1;
    scan_address <= addr;
    scan_write_data <= data;
    @(posedge core_clk);
    scan_enable <= 1'b0;
    scan_write_enable <= 1'b0;
    scan_address <= ~addr;
    scan_write_data <= ~data;
    busy_seen = 1'b0;
    // busy stands only in the cycle after the strobe, so look before the next edge
    repeat (4) begin
      #1;
      if (scan_access_busy === 1'b1) busy_seen = 1'b1;
      if (scan_ack === 1'b1) break;
      @(posedge core_clk);
    end
  endtask

  // read data is taken only while the ack stands; otherwise it is returned unknown
  task automatic read(input logic [6:0] addr, output logic [15:0] rd);
    @(posedge core_clk);
    scan_enable <= 1'b1;
    scan_write_enable <= 1'b0;
    scan_address <= addr;
    @(posedge core_clk);
    scan_enable <= 1'b0;
    scan_address <= ~addr;
    @(posedge core_clk);
    #1;
    rd = (scan_ack === 1'b1) ? scan_read_data : 16'hxxxx;
  endtask
endmodule

`default_nettype wire

/* File: dv/adc_monitor_status_ports_tb.sv */
// self-checking bench for the converter control and status port logic
`timescale 1ns/1ps
`default_nettype none

module adc_monitor_status_ports_tb;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic event_mode = 1'b1;
  logic use_trigger_clock = 1'b0;
  logic external_mux_mode = 1'b1;
  logic calibrate_request = 1'b0;
  logic [31:0] sequence_mask = 32'h00000000;
  logic conversion_trigger = 1'b0;
  logic trigger_clock_input = 1'b0;
  logic [6:0] sensor_alarm_in = 7'h00;
  logic overheat_in = 1'b0;
  logic port_enable = 1'b0;
  logic port_write_enable = 1'b0;
  logic [6:0] port_address = 7'h00;
  logic [15:0] port_write_data = 16'h0000;
  logic [7:0] alarm;
  logic [4:0] external_mux_select, channel;
  logic [15:0] port_read_data, scan_read_data, scan_write_data;
  logic [6:0] scan_address;
  logic overheat_alarm, conversion_done, sequence_done, busy, port_ack, scan_ack;
  logic scan_lock_request, scan_enable, scan_write_enable;
  logic port_lock_flag, scan_write_flag, scan_access_busy;
  int errors = 0;
  int checked = 0;

  always #2 core_clk = ~core_clk;

  adc_monitor_status_ports adc_monitor_status_ports_inst (
    .core_clk(core_clk), .reset(reset), .clk_en(1'b1), .event_mode(event_mode),
    .use_trigger_clock(use_trigger_clock), .external_mux_mode(external_mux_mode),
    .calibrate_request(calibrate_request), .sequence_mask(sequence_mask),
    .conversion_trigger(conversion_trigger), .trigger_clock_input(trigger_clock_input),
    .sample_data(12'habc), .sensor_alarm_in(sensor_alarm_in), .overheat_in(overheat_in),
    .alarm(alarm), .overheat_alarm(overheat_alarm), .external_mux_select(external_mux_select),
    .channel(channel), .conversion_done(conversion_done), .sequence_done(sequence_done),
    .busy(busy), .port_enable(port_enable), .port_write_enable(port_write_enable),
    .port_address(port_address), .port_write_data(port_write_data),
    .port_read_data(port_read_data), .port_ack(port_ack),
    .scan_lock_request(scan_lock_request), .scan_enable(scan_enable),
    .scan_write_enable(scan_write_enable), .scan_address(scan_address),
    .scan_write_data(scan_write_data), .scan_read_data(scan_read_data), .scan_ack(scan_ack),
    .port_lock_flag(port_lock_flag), .scan_write_flag(scan_write_flag),
    .scan_access_busy(scan_access_busy)
  );

  scan_tap_model scan_tap_model_inst (
    .core_clk(core_clk), .scan_ack(scan_ack), .scan_access_busy(scan_access_busy),
    .scan_read_data(scan_read_data),
    .scan_lock_request(scan_lock_request), .scan_enable(scan_enable),
    .scan_write_enable(scan_write_enable), .scan_address(scan_address),
    .scan_write_data(scan_write_data)
  );

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      errors++;
      $display("CHECK FAILED at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // the ack comes exactly one cycle after the strobe, so the wait is fixed
  task automatic port_access(input logic we, input logic [6:0] addr, input logic [15:0] data,
                             output logic [15:0] rd);
    @(posedge core_clk);
    port_enable <= 1'b1;
    port_write_enable <= we;
    port_address <= addr;
    port_write_data <= data;
    @(posedge core_clk);
    port_enable <= 1'b0;
    port_write_enable <= ~we;
    port_address <= ~addr;
    port_write_data <= ~data;
    #1;
    check(port_ack === 1'b1, "no port ack");
    rd = port_read_data;
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic test_reset();
    repeat (4) @(posedge core_clk);
    #1;
    check({alarm, busy, conversion_done, port_ack, port_lock_flag} === 12'h000, "reset");
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    $display("test reset done");
  endtask

  task automatic test_alarm();
    logic [6:0] v;
    for (int i = 0; i < 8; i++) begin
      v = (i < 7) ? 7'(1 << i) : 7'h00;
      @(posedge core_clk);
      sensor_alarm_in <= v;
      overheat_in <= ~overheat_in;
      @(posedge core_clk);
      #1;
      check(alarm === {|v, v}, "alarm bits");
      check(overheat_alarm === overheat_in, "overheat");
    end
    $display("test alarm done");
  endtask

  task automatic test_conv(input logic by_clock, input logic [31:0] mask, input logic seq);
    int n;
    @(posedge core_clk);
    use_trigger_clock <= by_clock;
    sequence_mask <= mask;
    @(posedge core_clk);
    if (by_clock) trigger_clock_input <= 1'b1;
    else conversion_trigger <= 1'b1;
    @(posedge core_clk);
    trigger_clock_input <= 1'b0;
    conversion_trigger <= 1'b0;
    n = 0;
    while (n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
      if (conversion_done === 1'b1) break;
      check(busy === 1'b1, "busy low in conversion");
    end
    check(n == 26, "conversion length");
    check(channel === 5'h00 && sequence_done === seq, "channel or sequence flag");
    check(external_mux_select === 5'h00, "next channel");
    @(posedge core_clk);
    #1;
    check({conversion_done, sequence_done} === 2'b00, "done not a pulse");
    $display("test conversion done");
  endtask

  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (conversion_done !== 1'b1 && n < 40);
  endtask

  // continuous mode over a two-channel sequence; mux select off for the second conversion
  task automatic test_seq();
    int n;
    @(posedge core_clk);
    sequence_mask <= 32'h00000003;
    event_mode <= 1'b0;
    wait_done(n);
    check(n == 27 && channel === 5'h00 && sequence_done === 1'b0, "first of sequence");
    check(external_mux_select === 5'h01 && busy === 1'b0, "mux select or idle gap");
    @(posedge core_clk);
    external_mux_mode <= 1'b0;
    event_mode <= 1'b1;
    wait_done(n);
    check(n == 26 && channel === 5'h01 && sequence_done === 1'b1, "last of sequence");
    check(external_mux_select === 5'h00, "mux select outside external mode");
    @(posedge core_clk);
    external_mux_mode <= 1'b1;
    $display("test sequence done");
  endtask

  task automatic test_cal();
    int n;
    @(posedge core_clk);
    calibrate_request <= 1'b1;
    @(posedge core_clk);
    calibrate_request <= 1'b0;
    n = 0;
    repeat (1010) begin
      #1;
      if (busy === 1'b1) n++;
      check(conversion_done === 1'b0, "done in calibration");
      @(posedge core_clk);
    end
    check(n == 1000, "calibration busy length");
    $display("test calibration done");
  endtask

  task automatic test_port();
    logic [15:0] rd;
    port_access(1'b1, 7'h20, 16'h5a3c, rd);
    port_access(1'b0, 7'h20, 16'h0000, rd);
    check(rd === 16'h5a3c, "read back");
    scan_tap_model_inst.lock(1'b1);
    @(posedge core_clk);
    #1;
    check(port_lock_flag === 1'b1, "lock flag low");
    port_access(1'b1, 7'h20, 16'h1111, rd);
    scan_tap_model_inst.lock(1'b0);
    @(posedge core_clk);
    #1;
    check(port_lock_flag === 1'b0, "lock flag stuck");
    port_access(1'b0, 7'h20, 16'h0000, rd);
    check(rd === 16'h5a3c, "write taken while locked");
    scan_tap_model_inst.write(7'h21, 16'hc3a5);
    check(scan_tap_model_inst.busy_seen === 1'b1, "scan busy missing");
    check(scan_write_flag === 1'b1, "scan write flag low");
    port_access(1'b0, 7'h21, 16'h0000, rd);
    check(rd === 16'hc3a5, "scan data");
    scan_tap_model_inst.read(7'h21, rd);
    check(rd === 16'hc3a5, "scan read data");
    port_access(1'b1, 7'h21, 16'h0000, rd);
    check(scan_write_flag === 1'b0, "scan write flag stuck");
    $display("test port done");
  endtask

  initial begin
    #50000;
    errors++;
    $display("CHECK FAILED at %0t ns: watchdog", $time);
    stop_test();
  end

  initial begin
    test_reset();
    test_alarm();
    test_conv(1'b0, 32'h00000000, 1'b0);
    test_conv(1'b1, 32'h00000001, 1'b1);
    test_seq();
    test_cal();
    test_port();
    stop_test();
  end
endmodule

`default_nettype wire
